//--- logic/bac_pkg.sv
/*
 * Constants for the bridge readout block.
 * Assumes one 125 MHz clock and a 12-bit converter, 5 V full scale.
 */
`default_nettype none
package bac_pkg;
    // Clock and sequencing
    localparam int CLK_HZ            = 125_000_000;
    localparam int SAMPLE_PERIOD_MS  = 50;
    localparam int NUM_CH            = 4;
    localparam int SLOT_CYCLES       =
        CLK_HZ / 1000 * SAMPLE_PERIOD_MS / NUM_CH;
    localparam int PWM_HZ            = 25_000;
    localparam int PWM_HALF_CYCLES   = CLK_HZ / (2 * PWM_HZ);
    localparam int PLL_PRESCALE      = 5;
    localparam int RECAL_PULSE_NS    = 1000;
    localparam int RECAL_CYCLES      = RECAL_PULSE_NS * (CLK_HZ / 1_000_000)
                                       / 1000;

    // Data widths
    localparam int ADC_W     = 12;
    localparam int AVG_FRAC  = 8;
    localparam int AVG_W     = ADC_W + AVG_FRAC + 1;
    localparam int WORD_W    = 32;
    localparam int READ_WORDS = 8;
    localparam int V_SHIFT   = 3;   // Q8 counts to Q16 of 2.5 V
    localparam int RES_SHIFT = 2;   // Q16 q times 64 ohm, to Q8 ohm

    // Channel order
    localparam logic [1:0] CH_AMP1_SIG = 2'h0;
    localparam logic [1:0] CH_AMP1_REF = 2'h1;
    localparam logic [1:0] CH_AMP2_SIG = 2'h2;
    localparam logic [1:0] CH_AMP2_REF = 2'h3;

    // Polynomial coefficients, Q16; base resistance, Q8
    localparam logic signed [31:0] K0_Q16 = 32'sh0000_0001;
    localparam logic signed [31:0] K1_Q16 = 32'sh0000_8111;
    localparam logic signed [31:0] K2_Q16 = 32'sh0000_131B;
    localparam logic signed [31:0] K3_Q16 = 32'sh0000_0382;
    localparam logic signed [31:0] A0_Q16 = -32'sh0000_5001;
    localparam logic signed [31:0] A1_Q16 = 32'sh0001_9044;
    localparam logic signed [31:0] A2_Q16 = -32'sh0000_0F39;
    localparam logic signed [31:0] R_BASE_Q8 = 32'sh0000_7800;

    // Alpha 2/(n+1), Q16, by log2(n); entry 0 holds the n = 2 value
    localparam logic [16:0] ALPHA_Q16 [8] = '{
        17'hAAAB, 17'hAAAB, 17'h6666, 17'h38E4,
        17'h1E1E, 17'h0F84, 17'h07E0, 17'h03F8
    };

    typedef enum logic { BAC_POLY_TEMP, BAC_POLY_RES } bac_poly_mode_t;
endpackage : bac_pkg
`default_nettype wire

//--- logic/bac_poly_if.sv
/*
 * Request and answer bundle between the sequencer and the polynomial unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bac_poly_if;
    import bac_pkg::*;
    logic                  start;
    bac_poly_mode_t        mode;
    logic signed [31:0]    arg;
    logic                  done;
    logic                  busy;
    logic signed [31:0]    result;

    modport ctrl (output start, mode, arg, input done, busy, result);
    modport unit (input start, mode, arg, output done, busy, result);
endinterface : bac_poly_if
`default_nettype wire

//--- logic/bac_ema.sv
/*
 * One channel of exponential averaging, Q8 fraction.
 * Assumes sample_valid is a one-cycle pulse on the module clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bac_ema
    import bac_pkg::*;
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // Control
    input  wire logic                    avg_enable,
    input  wire logic [2:0]              avg_log2n,
    input  wire logic                    restart,
    // Sample in, value out
    input  wire logic                    sample_valid,
    input  wire logic [ADC_W-1:0]        sample,
    output logic signed [AVG_W-1:0]      value_reg
);
    logic                     first_reg;
    logic signed [AVG_W-1:0]  x_q8;
    logic signed [AVG_W:0]    diff;
    logic signed [AVG_W+18:0] prod;
    logic signed [AVG_W-1:0]  value_next;

    always_comb begin
        x_q8 = AVG_W'({1'b0, sample, {AVG_FRAC{1'b0}}});
        diff = (AVG_W+1)'(x_q8) - (AVG_W+1)'(value_reg);
        prod = (AVG_W+19)'(diff) *
               (AVG_W+19)'($signed({1'b0, ALPHA_Q16[avg_log2n]}));
        value_next = value_reg + AVG_W'(prod >>> 16);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            value_reg <= '0;
            first_reg <= 1'b1;
        end else begin
            if (restart) begin
                first_reg <= 1'b1;
            end
            if (sample_valid) begin
                if (!avg_enable || first_reg || restart) begin
                    value_reg <= x_q8;
                end else begin
                    value_reg <= value_next;
                end
                first_reg <= !avg_enable;
            end
        end
    end
endmodule : bac_ema
`default_nettype wire

//--- logic/bac_poly.sv
/*
 * Horner evaluator, cubic or quadratic, one multiply per cycle.
 * Assumes start only while busy is low.
 */
`timescale 1ns/1ps
`default_nettype none
module bac_poly
    import bac_pkg::*;
(
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  reset_n,
    // Requests
    bac_poly_if.unit   req
);
    typedef enum logic { BAC_PS_IDLE, BAC_PS_STEP } bac_pstate_t;

    bac_pstate_t          state_reg;
    bac_poly_mode_t       mode_reg;
    logic [1:0]           left_reg;
    logic signed [31:0]   arg_reg;
    logic signed [31:0]   acc_reg;
    logic                 done_reg;
    logic signed [63:0]   prod;
    logic signed [31:0]   coef;

    always_comb begin
        prod = 64'(arg_reg) * 64'(acc_reg);
        if (mode_reg == BAC_POLY_TEMP) begin
            case (left_reg)
                2'h3:    coef = K2_Q16;
                2'h2:    coef = K1_Q16;
                default: coef = K0_Q16;
            endcase
        end else begin
            coef = (left_reg == 2'h2) ? A1_Q16 : A0_Q16;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg <= BAC_PS_IDLE;
            mode_reg  <= BAC_POLY_TEMP;
            left_reg  <= 2'h0;
            arg_reg   <= '0;
            acc_reg   <= '0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                BAC_PS_IDLE: begin
                    if (req.start) begin
                        mode_reg  <= req.mode;
                        arg_reg   <= req.arg;
                        state_reg <= BAC_PS_STEP;
                        if (req.mode == BAC_POLY_TEMP) begin
                            acc_reg  <= K3_Q16;
                            left_reg <= 2'h3;
                        end else begin
                            acc_reg  <= A2_Q16;
                            left_reg <= 2'h2;
                        end
                    end
                end
                BAC_PS_STEP: begin
                    // Full product keeps error under 1 LSB
                    acc_reg  <= coef + 32'(prod >>> 16);
                    left_reg <= left_reg - 2'h1;
                    if (left_reg == 2'h1) begin
                        state_reg <= BAC_PS_IDLE;
                        done_reg  <= 1'b1;
                    end
                end
                default: state_reg <= BAC_PS_IDLE;
            endcase
        end
    end

    assign req.done   = done_reg;
    assign req.busy   = (state_reg != BAC_PS_IDLE);
    assign req.result = acc_reg;
endmodule : bac_poly
`default_nettype wire

//--- logic/bac_top.sv
/*
 * Bridge readout: ADC sequencing, averaging,
 * reference subtraction, temperature and resistance,
 * host readout, square wave, PLL tick.
 * Assumes async ADC pins;
 * host ports come from ref_clk logic.
 */
// Functional notes
// - four inputs multiplexed into one 12-bit converter
// - order: amp1 signal, amp1 ref, amp2 signal, ref
// - each channel sampled every 50 ms
// - input voltage is signal minus reference
// - averaging off: latest raw sample offered
// - averaging on: moving average updated per sample
// - average weight alpha equals 2/(n+1), n power of two; log2(n) of 0 gives the n = 2 weight
// - two independent temperature estimates
// - scaled cubic converts voltage to temperature
// - quadratic rebuilds resistance from temperature
// - continuous 25 kHz 50% square wave output
// - reference divided by five for PLL
// - readout order: channels, temperatures, resistances
// - temperature minus host calibration, zero at reset
`timescale 1ns/1ps
`default_nettype none
module bac_top
    import bac_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // Converter
    output logic                     adc_convert_reg,
    output logic [1:0]               adc_channel_reg,
    input  wire logic                adc_done,
    input  wire logic [ADC_W-1:0]    adc_data,
    // Host configuration
    input  wire logic                avg_enable,
    input  wire logic [2:0]          avg_log2n,
    input  wire logic                cal_write,
    input  wire logic                cal_select,
    input  wire logic signed [31:0]  cal_value,
    input  wire logic                recal_request,
    // Host readout
    input  wire logic                read_request,
    output logic                     read_valid_reg,
    output logic [2:0]               read_index_reg,
    output logic [WORD_W-1:0]        read_word_reg,
    output logic                     results_fresh_reg,
    // Board outputs
    output logic                     offset_recal_strobe_reg,
    output logic                     interference_pwm_reg,
    output logic                     pll_ref_tick_reg
);
    typedef enum logic [2:0] {
        BAC_J_IDLE, BAC_J_TEMP, BAC_J_WAIT_T, BAC_J_WAIT_R
    } bac_jstate_t;

    // Pin synchronisers
    logic                  done_s1_reg;
    logic                  done_s2_reg;
    logic                  done_s3_reg;
    logic [ADC_W-1:0]      data_s1_reg;
    logic [ADC_W-1:0]      data_s2_reg;
    // Sequencing
    logic [31:0]           slot_cnt_reg;
    logic [1:0]            conv_ch_reg;
    logic [NUM_CH-1:0]     sample_valid_reg;
    logic [NUM_CH-1:0]     sample_valid_d_reg;
    logic                  restart_reg;
    logic                  avg_en_d_reg;
    logic [2:0]            log2n_d_reg;
    logic signed [AVG_W-1:0] ema_val [NUM_CH];
    // Conversion jobs
    bac_jstate_t           jstate_reg;
    logic [1:0]            pend_reg;
    logic                  job_amp_reg;
    logic signed [31:0]    cal_reg [2];
    logic signed [31:0]    temp_reg [2];
    logic signed [31:0]    res_reg [2];
    logic                  start_reg;
    bac_poly_mode_t        mode_reg;
    logic signed [31:0]    arg_reg;
    logic signed [AVG_W:0] diff_q8;
    logic signed [31:0]    temp_corr;
    logic [1:0]            pend_set;
    logic [1:0]            pend_clr;
    // Misc counters
    logic [3:0]            read_cnt_reg;
    logic [15:0]           pwm_cnt_reg;
    logic [2:0]            pll_cnt_reg;
    logic [15:0]           recal_cnt_reg;

    bac_poly_if poly_bus ();

    // ADC pins cross into ref_clk via two flops
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
            data_s1_reg <= '0;
            data_s2_reg <= '0;
        end else begin
            done_s1_reg <= adc_done;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
            data_s1_reg <= adc_data;
            data_s2_reg <= data_s1_reg;
        end
    end

    // Four gapless slots per 50 ms
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            slot_cnt_reg    <= '0;
            adc_convert_reg <= 1'b0;
            adc_channel_reg <= CH_AMP1_SIG;
            conv_ch_reg     <= CH_AMP1_SIG;
        end else begin
            adc_convert_reg <= 1'b0;
            if (slot_cnt_reg == 32'(SLOT_LEN - 1)) begin
                slot_cnt_reg    <= '0;
                adc_convert_reg <= 1'b1;
                conv_ch_reg     <= adc_channel_reg;
                adc_channel_reg <= adc_channel_reg + 2'h1;
            end else begin
                slot_cnt_reg <= slot_cnt_reg + 32'h1;
            end
        end
    end

    // Capture on rising synced done
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sample_valid_reg   <= '0;
            sample_valid_d_reg <= '0;
        end else begin
            sample_valid_reg <= '0;
            if (done_s2_reg && !done_s3_reg) begin
                sample_valid_reg[conv_ch_reg] <= 1'b1;
            end
            sample_valid_d_reg <= sample_valid_reg;
        end
    end

    // Restart averages on enable rise or a new count
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            avg_en_d_reg <= 1'b0;
            log2n_d_reg  <= 3'h1;
            restart_reg  <= 1'b0;
        end else begin
            avg_en_d_reg <= avg_enable;
            log2n_d_reg  <= avg_log2n;
            restart_reg  <= (avg_enable && !avg_en_d_reg) ||
                            (avg_log2n != log2n_d_reg);
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ema
        bac_ema u_ema (
            .ref_clk      (ref_clk),
            .reset_n      (reset_n),
            .avg_enable   (avg_enable),
            .avg_log2n    (avg_log2n),
            .restart      (restart_reg),
            .sample_valid (sample_valid_reg[i]),
            .sample       (data_s2_reg),
            .value_reg    (ema_val[i])
        );
    end

    bac_poly u_poly (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .req     (poly_bus.unit)
    );

    assign poly_bus.start = start_reg;
    assign poly_bus.mode  = mode_reg;
    assign poly_bus.arg   = arg_reg;

    // Calibration offsets, zero until written
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cal_reg[0] <= '0;
            cal_reg[1] <= '0;
        end else if (cal_write) begin
            cal_reg[cal_select] <= cal_value;
        end
    end

    always_comb begin
        // Subtraction cancels reference error
        if (job_amp_reg) begin
            diff_q8 = (AVG_W+1)'(ema_val[CH_AMP2_SIG]) -
                      (AVG_W+1)'(ema_val[CH_AMP2_REF]);
        end else begin
            diff_q8 = (AVG_W+1)'(ema_val[CH_AMP1_SIG]) -
                      (AVG_W+1)'(ema_val[CH_AMP1_REF]);
        end
        temp_corr = poly_bus.result - cal_reg[job_amp_reg];
        pend_set  = {sample_valid_d_reg[CH_AMP2_REF],
                     sample_valid_d_reg[CH_AMP1_REF]};
        pend_clr  = '0;
        if (jstate_reg == BAC_J_WAIT_R && poly_bus.done) begin
            pend_clr[job_amp_reg] = 1'b1;
        end
    end

    // Set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~pend_clr) | pend_set;
        end
    end

    // Job sequencer: temperature, then resistance, per amplifier
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            jstate_reg        <= BAC_J_IDLE;
            job_amp_reg       <= 1'b0;
            start_reg         <= 1'b0;
            mode_reg          <= BAC_POLY_TEMP;
            arg_reg           <= '0;
            temp_reg[0]       <= '0;
            temp_reg[1]       <= '0;
            res_reg[0]        <= '0;
            res_reg[1]        <= '0;
            results_fresh_reg <= 1'b0;
        end else begin
            start_reg         <= 1'b0;
            results_fresh_reg <= 1'b0;
            case (jstate_reg)
                BAC_J_IDLE: begin
                    if (pend_reg != 2'h0) begin
                        job_amp_reg <= !pend_reg[0];
                        jstate_reg  <= BAC_J_TEMP;
                    end
                end
                BAC_J_TEMP: begin
                    start_reg  <= 1'b1;
                    mode_reg   <= BAC_POLY_TEMP;
                    arg_reg    <= 32'(diff_q8 >>> V_SHIFT);
                    jstate_reg <= BAC_J_WAIT_T;
                end
                BAC_J_WAIT_T: begin
                    if (poly_bus.done) begin
                        // Q16 w times 256 degC is the Q8 temperature
                        temp_reg[job_amp_reg] <= temp_corr;
                        start_reg  <= 1'b1;
                        mode_reg   <= BAC_POLY_RES;
                        arg_reg    <= temp_corr;
                        jstate_reg <= BAC_J_WAIT_R;
                    end
                end
                BAC_J_WAIT_R: begin
                    if (poly_bus.done) begin
                        res_reg[job_amp_reg] <= R_BASE_Q8 +
                            (poly_bus.result >>> RES_SHIFT);
                        results_fresh_reg <= 1'b1;
                        jstate_reg        <= BAC_J_IDLE;
                    end
                end
                default: jstate_reg <= BAC_J_IDLE;
            endcase
        end
    end

    // Eight-word burst; requests during its first seven words are ignored
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            read_cnt_reg   <= '0;
            read_valid_reg <= 1'b0;
            read_index_reg <= '0;
            read_word_reg  <= '0;
        end else begin
            read_valid_reg <= 1'b0;
            if (read_cnt_reg != 4'h0 || read_request) begin
                read_valid_reg <= 1'b1;
                read_index_reg <= read_cnt_reg[2:0];
                case (read_cnt_reg[2:0])
                    3'h0: read_word_reg <= 32'(ema_val[0]);
                    3'h1: read_word_reg <= 32'(ema_val[1]);
                    3'h2: read_word_reg <= 32'(ema_val[2]);
                    3'h3: read_word_reg <= 32'(ema_val[3]);
                    3'h4: read_word_reg <= temp_reg[0];
                    3'h5: read_word_reg <= temp_reg[1];
                    3'h6: read_word_reg <= res_reg[0];
                    default: read_word_reg <= res_reg[1];
                endcase
                if (read_cnt_reg == 4'(READ_WORDS - 1)) begin
                    read_cnt_reg <= '0;
                end else begin
                    read_cnt_reg <= read_cnt_reg + 4'h1;
                end
            end
        end
    end

    // Interference square wave, free running
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pwm_cnt_reg          <= '0;
            interference_pwm_reg <= 1'b0;
        end else if (pwm_cnt_reg == 16'(PWM_HALF_CYCLES - 1)) begin
            pwm_cnt_reg          <= '0;
            interference_pwm_reg <= !interference_pwm_reg;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 16'h1;
        end
    end

    // Divide-by-five enable standing in for the PLL prescaler
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pll_cnt_reg      <= '0;
            pll_ref_tick_reg <= 1'b0;
        end else begin
            pll_ref_tick_reg <= (pll_cnt_reg == 3'(PLL_PRESCALE - 1));
            if (pll_cnt_reg == 3'(PLL_PRESCALE - 1)) begin
                pll_cnt_reg <= '0;
            end else begin
                pll_cnt_reg <= pll_cnt_reg + 3'h1;
            end
        end
    end

    // Recal pulse, long enough for the amplifier pin
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            recal_cnt_reg           <= '0;
            offset_recal_strobe_reg <= 1'b0;
        end else if (recal_request && recal_cnt_reg == 16'h0) begin
            recal_cnt_reg           <= 16'(RECAL_CYCLES);
            offset_recal_strobe_reg <= 1'b1;
        end else if (recal_cnt_reg != 16'h0) begin
            recal_cnt_reg           <= recal_cnt_reg - 16'h1;
            offset_recal_strobe_reg <= (recal_cnt_reg != 16'h1);
        end
    end
endmodule : bac_top
`default_nettype wire

//--- sim/bac_top_properties.sv
/* Port checker for bac_top, one clock.
   Bound to every bac_top. */
`timescale 1ns/1ps
`default_nettype none
module bac_top_properties
    import bac_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // Watched ports
    input wire logic       adc_convert_reg,
    input wire logic [1:0] adc_channel_reg,
    input wire logic       read_request,
    input wire logic       read_valid_reg,
    input wire logic [2:0] read_index_reg,
    input wire logic       results_fresh_reg,
    input wire logic       interference_pwm_reg,
    input wire logic       pll_ref_tick_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    int   gap_reg;
    int   run_reg;
    logic last_reg;
    logic conv_seen_reg;
    logic pwm_seen_reg;
    // Runs from reset are skipped
    always_ff @(posedge ref_clk) begin
        conv_seen_reg <= reset_n && (conv_seen_reg || adc_convert_reg);
        gap_reg <= (!reset_n || adc_convert_reg) ? 1 : gap_reg + 1;
        last_reg <= reset_n && interference_pwm_reg;
        pwm_seen_reg <= reset_n && (pwm_seen_reg ||
                        interference_pwm_reg != last_reg);
        run_reg <= (!reset_n || interference_pwm_reg != last_reg) ?
                   1 : run_reg + 1;
    end
    a_slot_spacing: assert property (adc_convert_reg && conv_seen_reg |->
        gap_reg == SLOT_LEN) else $error("bad spacing");
    a_channel_step: assert property ($changed(adc_channel_reg) |->
        adc_channel_reg == $past(adc_channel_reg) + 2'h1)
        else $error("bad order");
    a_pwm_half: assert property (pwm_seen_reg &&
        interference_pwm_reg != last_reg |-> run_reg == PWM_HALF_CYCLES)
        else $error("bad half period");
    a_pwm_bound: assert property (pwm_seen_reg |->
        run_reg <= PWM_HALF_CYCLES) else $error("wave stalled");
    a_tick_period: assert property (pll_ref_tick_reg |=>
        !pll_ref_tick_reg [*4] ##1 pll_ref_tick_reg)
        else $error("bad tick");
    a_burst_start: assert property (read_request && !read_valid_reg |=>
        read_valid_reg && read_index_reg == 3'h0)
        else $error("no burst");
    a_burst_order: assert property (read_valid_reg && read_index_reg != 3'h7
        |=> read_valid_reg && read_index_reg == $past(read_index_reg) + 3'h1)
        else $error("bad index");
    a_burst_end: assert property (read_valid_reg && read_index_reg == 3'h7
        && !read_request |=> !read_valid_reg) else $error("long burst");
    a_fresh_pulse: assert property (results_fresh_reg |=>
        !results_fresh_reg) else $error("fresh not pulse");
endmodule // bac_top_properties
bind bac_top bac_top_properties #(.SLOT_LEN(SLOT_LEN)) u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .adc_convert_reg(adc_convert_reg),
    .adc_channel_reg(adc_channel_reg), .read_request(read_request),
    .read_valid_reg(read_valid_reg), .read_index_reg(read_index_reg),
    .results_fresh_reg(results_fresh_reg),
    .interference_pwm_reg(interference_pwm_reg),
    .pll_ref_tick_reg(pll_ref_tick_reg));
`default_nettype wire

//--- sim/bac_adc_model.sv
/* Converter model for bac_top.
   Bench supplies each channel value. */
`timescale 1ns/1ps
`default_nettype none
module bac_adc_model
    import bac_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // Converter side
    input  wire logic                  adc_convert_reg,
    output logic                       adc_done,
    output logic [ADC_W-1:0]           adc_data,
    // Bench side
    input  wire logic [3:0][ADC_W-1:0] chan_value,
    output logic [1:0]                 conv_seq_reg,
    output logic                       conv_start_reg
);
    logic [3:0]       wait_reg = 4'h0;
    logic [ADC_W-1:0] value_reg = '0;
    // Own count: wrong order gives wrong data
    always_ff @(posedge ref_clk) begin
        conv_start_reg <= reset_n && adc_convert_reg;
        if (!reset_n) begin
            wait_reg <= 4'h0;
            conv_seq_reg <= 2'h3;
        end else if (adc_convert_reg) begin
            conv_seq_reg <= conv_seq_reg + 2'h1;
            value_reg <= chan_value[conv_seq_reg + 2'h1];
            wait_reg <= 4'hC;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
    // Valid from before done rises, else inverted
    assign adc_done = wait_reg != 4'h0 && wait_reg < 4'h8;
    assign adc_data = (wait_reg != 4'h0 && wait_reg < 4'h9) ?
                      value_reg : ~value_reg;
endmodule // bac_adc_model
`default_nettype wire

//--- sim/tb_top.sv
/* Bench for bac_top with the converter model.
   Short slots; every wait is bounded. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bac_pkg::*;
    localparam int SLOT = 200;
    logic ref_clk = 1'b0, reset_n = 1'b0, avg_enable = 1'b0;
    logic cal_write = 1'b0, cal_select = 1'b0, read_request = 1'b0;
    logic [2:0] avg_log2n = 3'h0;
    logic signed [31:0] cal_value = 32'sh0;
    logic adc_done, adc_convert_reg, read_valid_reg, fresh, pwm, conv_start;
    logic [ADC_W-1:0] adc_data;
    logic [1:0] adc_channel_reg, conv_seq;
    logic [2:0] read_index_reg;
    logic [WORD_W-1:0] read_word_reg, words [8];
    logic [3:0][ADC_W-1:0] chan_value = {12'h708, 12'h708, 12'h400, 12'h800};
    int failures = 0, total_checks = 0, n;
    always #4 ref_clk = ~ref_clk;
    bac_top #(.SLOT_LEN(SLOT)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .adc_convert_reg(adc_convert_reg), .adc_channel_reg(adc_channel_reg),
        .adc_done(adc_done), .adc_data(adc_data), .avg_enable(avg_enable),
        .avg_log2n(avg_log2n), .cal_write(cal_write), .cal_select(cal_select),
        .cal_value(cal_value), .recal_request(1'b0),
        .read_request(read_request), .read_valid_reg(read_valid_reg),
        .read_index_reg(read_index_reg), .read_word_reg(read_word_reg),
        .results_fresh_reg(fresh), .offset_recal_strobe_reg(),
        .interference_pwm_reg(pwm), .pll_ref_tick_reg());
    bac_adc_model u_adc (.ref_clk(ref_clk), .reset_n(reset_n),
        .adc_convert_reg(adc_convert_reg), .adc_done(adc_done),
        .adc_data(adc_data), .chan_value(chan_value),
        .conv_seq_reg(conv_seq), .conv_start_reg(conv_start));
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] near(input logic [31:0] s, input int x);
        return 32'(($signed(s) - x) inside {[-8:8]});
    endfunction
    task step;
        @(posedge ref_clk);
        #1;
    endtask
    task give_up_if(input logic hung);
        if (hung) begin
            failures++;
            report_and_stop();
        end
    endtask
    task wait_conv(input logic [1:0] ch);
        n = 0;
        do begin step(); n++; end
        while (!(conv_start === 1'b1 && conv_seq === ch) && n < 2000);
        give_up_if(n >= 2000);
    endtask
    task run_while(input logic lvl);
        n = 0;
        while (pwm === lvl && n < 6000) begin step(); n++; end
        give_up_if(n >= 6000);
    endtask
    task read_all;
        step();
        read_request = 1'b1;
        step();
        read_request = 1'b0;
        give_up_if(read_valid_reg !== 1'b1);
        for (int i = 0; i < 8; i++) begin
            words[i] = read_word_reg;
            step();
        end
    endtask
    initial begin
        repeat (6) step();
        reset_n = 1'b1;
        cal_write = 1'b1;
        cal_value = 32'sh100; // 1 degC on amp one
        step();
        cal_write = 1'b0;
        wait_conv(2'h0);
        wait_conv(2'h0);
        read_all();
        for (int i = 0; i < 4; i++) check(words[i], 32'(chan_value[i]) << 8);
        // v = 0.5 less offset; amp two v = 0
        check(near(words[4], 17601), 32'h1);
        check(words[5], K0_Q16);
        check(near(words[6], 32410), 32'h1);
        check(near(words[7], 25600), 32'h1);
        avg_log2n = 3'h1;
        avg_enable = 1'b1;
        wait_conv(2'h3);
        chan_value[3] = 12'h3E8;
        wait_conv(2'h3);
        wait_conv(2'h0);
        read_all();
        check(words[3], 32'(460800 +
            ((-204800 * longint'(ALPHA_Q16[1])) >>> 16)));
        check(words[0], 32'h80000);
        avg_log2n = 3'h3;
        wait_conv(2'h0);
        read_all();
        check(words[3], 32'h3E800);
        run_while(1'b1);
        run_while(1'b0);
        run_while(1'b1);
        check(n, PWM_HALF_CYCLES);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
